// ==== vsu_pkg.sv ====
package vsu_pkg;
    // Command word layout
    localparam int OPC_W = 5;
    localparam int ARG_W = 11;
    localparam int CMD_W = 16;
    localparam logic [4:0] OP_LPARAM = 5'h00;
    localparam logic [4:0] OP_LX = 5'h02;
    localparam logic [4:0] OP_LY = 5'h03;
    localparam logic [4:0] OP_LZ = 5'h04;
    localparam logic [4:0] OP_LA = 5'h05;
    localparam logic [4:0] OP_VMAC = 5'h08;
    localparam logic [4:0] OP_VMADD = 5'h09;
    localparam logic [4:0] OP_SPECIAL = 5'h10;
    localparam logic [10:0] ARG_LEA = 11'h533;
    localparam logic [10:0] ARG_HALT = 11'h000;
    localparam int ARG_TYPE_LSB = 0;
    localparam int ARG_TYPE_W = 2;
    // Operand types carried in the vector argument
    localparam logic [1:0] TY_INT = 2'h0;
    localparam logic [1:0] TY_REAL = 2'h1;
    localparam logic [1:0] TY_CPX = 2'h2;
    localparam logic [1:0] TY_EXT = 2'h3;
    // Vector pointer double word
    localparam int PTR_ADDR_LSB = 0;
    localparam int PTR_INCR_LSB = 16;
    localparam int PTR_INCR_W = 4;
    localparam int PTR_WRAP_LSB = 20;
    localparam int PTR_WRAP_W = 5;
    // Parameter double word
    localparam int PAR_LEN_LSB = 0;
    localparam int PAR_RND_BIT = 16;
    localparam int PAR_CLR_BIT = 17;
    // Accumulator
    localparam int ACC_W = 34;
    localparam int RND_BIT = 14;
    localparam int FRAC_LSB = 15;
    // APB map, byte addresses
    localparam int APB_AW = 16;
    localparam logic [15:0] OFS_START = 16'h0000;
    localparam logic [15:0] OFS_STATUS = 16'h0004;
    localparam logic [15:0] OFS_ABORT = 16'h0008;
    localparam logic [15:0] OFS_EXTBASE = 16'h000C;
    localparam logic [15:0] OFS_HALTFLG = 16'h0010;
    localparam logic [15:0] OFS_HALTMSK = 16'h0014;
    localparam logic [15:0] OFS_NMICAUSE = 16'h0018;
    localparam logic [15:0] OFS_PARAM = 16'h001C;
    localparam logic [15:0] OFS_XPTR = 16'h0020;
    localparam logic [15:0] OFS_YPTR = 16'h0024;
    localparam logic [15:0] OFS_ZPTR = 16'h0028;
    localparam logic [15:0] OFS_ACCRE = 16'h002C;
    localparam logic [15:0] OFS_ACCIM = 16'h0030;
    localparam logic [15:0] OFS_ACCHI = 16'h0034;
    localparam logic [3:0] RAM_WIN = 4'h1;
    localparam int RAM_WIN_LSB = 12;
    typedef enum logic [2:0] {VSU_IDLE, VSU_RUN, VSU_VEC, VSU_CPX, VSU_STORE} vsu_state_t;
endpackage : vsu_pkg

// ==== vsu_cmd_decoder.sv ====
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module vsu_cmd_decoder
#(
    parameter int RAM_AW = 11
) (
    input wire logic CLK_I, // System clock
    input wire logic RESET_N_I, // Async reset, active low
    input wire logic PSEL_I, // APB select
    input wire logic PENABLE_I, // APB enable
    input wire logic PWRITE_I, // APB direction
    input wire logic [vsu_pkg::APB_AW-1:0] PADDR_I, // APB byte address
    input wire logic [31:0] PWDATA_I, // APB write data
    output logic [31:0] PRDATA_O, // APB read data
    output logic PREADY_O, // APB ready
    output logic PSLVERR_O, // APB error, unmapped address
    output logic LIST_RUNNING_O, // Command list active
    output logic HALT_IRQ_O, // Halt interrupt, active high
    output logic NMI_REQ_O // Undefined operation NMI request
);
    import vsu_pkg::*;

    if (RAM_AW < 4 || RAM_AW > 16) begin : g_bad_ram_aw
        $error("RAM_AW must lie in 4..16");
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);

    logic [CMD_W-1:0] mem [0:(1<<RAM_AW)-1];
    vsu_state_t state_r;
    logic [15:0] pc_r;
    logic [15:0] elem_r;
    logic [1:0] vtype_r;
    logic madd_r;
    logic [31:0] param_r, x_ptr_r, y_ptr_r, z_ptr_r, ext_base_r;
    logic halt_irq_flags_r, halt_irq_mask_r, undefined_op_flag_r;
    logic signed [ACC_W-1:0] acc_re_r, acc_im_r;
    logic [31:0] prdata_r;

    // Element address generator for one pointer
    function automatic logic [15:0] elem_addr(input logic [31:0] ptr, input logic [15:0] n);
        logic [15:0] a;
        logic [PTR_INCR_W-1:0] inc;
        logic [PTR_WRAP_W-1:0] wr;
        logic [16:0] clr_m;
        logic [16:0] wrap_m;
        logic [31:0] step;
        a = ptr[PTR_ADDR_LSB +: 16];
        inc = ptr[PTR_INCR_LSB +: PTR_INCR_W];
        wr = ptr[PTR_WRAP_LSB +: PTR_WRAP_W];
        clr_m = (wr == '0) ? 17'h0 : (17'h1 << (wr - 5'h1)) - 17'h1;
        wrap_m = (17'h1 << wr) - 17'h1;
        step = {16'h0, n} << inc;
        elem_addr = (a & ~clr_m[15:0]) + ((a + step[15:0]) & wrap_m[15:0]);
    endfunction : elem_addr

    function automatic logic [RAM_AW-1:0] ra(input logic [15:0] a);
        ra = a[RAM_AW-1:0];
    endfunction : ra

    // APB decode
    logic apb_acc, apb_wr, ram_hit, mapped;
    assign apb_acc = PSEL_I && PENABLE_I;
    assign apb_wr = apb_acc && PWRITE_I;
    assign ram_hit = PADDR_I[APB_AW-1:RAM_WIN_LSB] == RAM_WIN;
    always_comb begin
        unique case (PADDR_I)
            OFS_START, OFS_STATUS, OFS_ABORT, OFS_EXTBASE, OFS_HALTFLG, OFS_HALTMSK,
            OFS_NMICAUSE, OFS_PARAM, OFS_XPTR, OFS_YPTR, OFS_ZPTR, OFS_ACCRE,
            OFS_ACCIM, OFS_ACCHI: mapped = 1'b1;
            default: mapped = ram_hit && PADDR_I[1:0] == 2'h0 &&
                (PADDR_I[RAM_WIN_LSB-1:2] >> RAM_AW) == '0;
        endcase
    end
    logic running, idle_wr;
    assign running = state_r != VSU_IDLE;
    // Memory and software-owned registers writable by software only while the list is idle
    assign idle_wr = apb_wr && !running;
    logic start_req, abort_req;
    assign start_req = idle_wr && PADDR_I == OFS_START;
    assign abort_req = apb_wr && PADDR_I == OFS_ABORT && running;

    // Command decode
    logic [CMD_W-1:0] cmd;
    logic [OPC_W-1:0] opc;
    logic [ARG_W-1:0] arg;
    logic [15:0] aaddr;
    logic [31:0] dword;
    assign cmd = mem[ra(pc_r)];
    assign opc = cmd[CMD_W-1 -: OPC_W];
    assign arg = cmd[ARG_W-1:0];
    assign aaddr = {5'h0, arg[ARG_W-1:1], 1'b0};
    assign dword = {mem[ra(aaddr + 16'h1)], mem[ra(aaddr)]};
    logic in_run, dec_lp, dec_lx, dec_ly, dec_lz, dec_la, dec_lea, dec_halt, dec_vec, dec_und;
    logic [1:0] arg_ty;
    assign in_run = state_r == VSU_RUN;
    assign arg_ty = arg[ARG_TYPE_LSB +: ARG_TYPE_W];
    assign dec_lp = in_run && opc == OP_LPARAM;
    assign dec_lx = in_run && opc == OP_LX;
    assign dec_ly = in_run && opc == OP_LY;
    assign dec_lz = in_run && opc == OP_LZ;
    assign dec_la = in_run && opc == OP_LA;
    assign dec_lea = in_run && opc == OP_SPECIAL && arg == ARG_LEA;
    assign dec_halt = in_run && opc == OP_SPECIAL && arg == ARG_HALT;
    assign dec_vec = in_run && arg[ARG_W-1:ARG_TYPE_W] == '0 &&
        (opc == OP_VMAC || (opc == OP_VMADD && (arg_ty == TY_INT || arg_ty == TY_REAL)));
    assign dec_und = in_run && !(dec_lp || dec_lx || dec_ly || dec_lz || dec_la ||
        dec_lea || dec_halt || dec_vec);

    // Element operands
    logic [15:0] x_a, y_a, z_a, len_m1;
    logic [15:0] xr, xi, yr, yi;
    logic last;
    assign x_a = elem_addr(x_ptr_r, elem_r);
    assign y_a = elem_addr(y_ptr_r, elem_r);
    assign z_a = elem_addr(z_ptr_r, madd_r ? elem_r : 16'h0);
    assign xr = mem[ra(x_a)];
    assign xi = mem[ra(x_a + 16'h1)];
    assign yr = mem[ra(y_a)];
    assign yi = mem[ra(y_a + 16'h1)];
    assign len_m1 = param_r[PAR_LEN_LSB +: 16] - 16'h1;
    assign last = elem_r == len_m1;
    logic signed [31:0] p_rr, p_ri, p_ii, p_ir;
    assign p_rr = $signed(xr) * $signed(yr);
    assign p_ri = $signed(xr) * $signed(yi);
    assign p_ii = $signed(xi) * $signed(yi);
    assign p_ir = $signed(xi) * $signed(yr);
    logic rnd_on;
    logic signed [ACC_W-1:0] seed, madd_sum, mac_sum;
    // Integer and extended never rounded
    assign rnd_on = param_r[PAR_RND_BIT] && (vtype_r == TY_REAL || vtype_r == TY_CPX);
    assign seed = rnd_on ? ACC_W'(34'h1 << RND_BIT) : '0;
    assign madd_sum = seed + ACC_W'(p_rr);
    // Extended accumulates in the imaginary half
    assign mac_sum = (vtype_r == TY_EXT ? acc_im_r : acc_re_r) + ACC_W'(p_rr);

    // Sequencer
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_r <= VSU_IDLE;
            pc_r <= '0;
            elem_r <= '0;
            vtype_r <= TY_INT;
            madd_r <= 1'b0;
        end else begin
            unique case (state_r)
                VSU_IDLE: begin
                    if (start_req) begin
                        state_r <= VSU_RUN;
                        pc_r <= PWDATA_I[15:0];
                    end
                end
                VSU_RUN: begin
                    if (abort_req || dec_halt || dec_und) begin
                        state_r <= VSU_IDLE;
                    end else begin
                        pc_r <= pc_r + 16'h1;
                        if (dec_vec) begin
                            state_r <= VSU_VEC;
                            elem_r <= '0;
                            vtype_r <= arg_ty;
                            madd_r <= opc == OP_VMADD;
                        end
                    end
                end
                VSU_VEC: begin
                    if (abort_req) begin
                        state_r <= VSU_IDLE;
                    end else if (vtype_r == TY_CPX) begin
                        state_r <= VSU_CPX;
                    end else if (last) begin
                        state_r <= madd_r ? VSU_RUN : VSU_STORE;
                    end else begin
                        elem_r <= elem_r + 16'h1;
                    end
                end
                VSU_CPX: begin
                    if (abort_req) begin
                        state_r <= VSU_IDLE;
                    end else if (last) begin
                        state_r <= VSU_STORE;
                    end else begin
                        state_r <= VSU_VEC;
                        elem_r <= elem_r + 16'h1;
                    end
                end
                VSU_STORE: state_r <= abort_req ? VSU_IDLE : VSU_RUN;
            endcase
        end
    end

    // Software-owned registers; the list only loads them through explicit commands
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            param_r <= '0;
            x_ptr_r <= '0;
            y_ptr_r <= '0;
            z_ptr_r <= '0;
            ext_base_r <= '0;
        end else begin
            if (idle_wr && PADDR_I == OFS_PARAM) param_r <= PWDATA_I;
            if (idle_wr && PADDR_I == OFS_XPTR) x_ptr_r <= PWDATA_I;
            if (idle_wr && PADDR_I == OFS_YPTR) y_ptr_r <= PWDATA_I;
            if (idle_wr && PADDR_I == OFS_ZPTR) z_ptr_r <= PWDATA_I;
            if (idle_wr && PADDR_I == OFS_EXTBASE) ext_base_r <= PWDATA_I;
            if (dec_lp && !abort_req) param_r <= dword;
            if (dec_lx && !abort_req) x_ptr_r <= dword;
            if (dec_ly && !abort_req) y_ptr_r <= dword;
            if (dec_lz && !abort_req) z_ptr_r <= dword;
        end
    end

    // Status flags; a set in the same cycle as a clear wins
    logic stop_evt;
    assign stop_evt = running && (abort_req || dec_halt || dec_und);
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            halt_irq_flags_r <= 1'b0;
            halt_irq_mask_r <= 1'b0;
            undefined_op_flag_r <= 1'b0;
        end else begin
            if (apb_wr && PADDR_I == OFS_HALTMSK) halt_irq_mask_r <= PWDATA_I[0];
            if (stop_evt) begin
                halt_irq_flags_r <= 1'b1;
            end else if (apb_wr && PADDR_I == OFS_HALTFLG && PWDATA_I[0]) begin
                halt_irq_flags_r <= 1'b0;
            end
            if (dec_und && !abort_req) begin
                undefined_op_flag_r <= 1'b1;
            end else if (apb_wr && PADDR_I == OFS_NMICAUSE && PWDATA_I[0]) begin
                undefined_op_flag_r <= 1'b0;
            end
        end
    end

    // Accumulator, two 34-bit halves
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            acc_re_r <= '0;
            acc_im_r <= '0;
        end else begin
            unique case (state_r)
                VSU_RUN: begin
                    if (dec_la) begin
                        acc_re_r <= {{3{dword[15]}}, dword[15:0],
                            param_r[PAR_RND_BIT], 14'h0};
                        acc_im_r <= {{3{dword[31]}}, dword[31:16], param_r[PAR_RND_BIT], 14'h0};
                    end else if (dec_lea) begin
                        acc_re_r <= {{3{dword[31]}}, dword[31:1]};
                        acc_im_r <= {{3{dword[31]}}, dword[31:1]};
                    end else if (dec_vec && opc == OP_VMAC && param_r[PAR_CLR_BIT]) begin
                        // Clear with rounding seed; clear off leaves it alone
                        if (param_r[PAR_RND_BIT] && (arg_ty == TY_REAL || arg_ty == TY_CPX)) begin
                            acc_re_r <= ACC_W'(34'h1 << RND_BIT);
                            acc_im_r <= ACC_W'(34'h1 << RND_BIT);
                        end else begin
                            acc_re_r <= '0;
                            acc_im_r <= '0;
                        end
                    end
                end
                VSU_VEC: begin
                    if (madd_r) begin
                        acc_re_r <= madd_sum;
                        acc_im_r <= madd_sum;
                    end else if (vtype_r == TY_CPX) begin
                        acc_re_r <= acc_re_r + ACC_W'(p_rr);
                        acc_im_r <= acc_im_r + ACC_W'(p_ri);
                    end else begin
                        acc_re_r <= mac_sum;
                        acc_im_r <= mac_sum;
                    end
                end
                VSU_CPX: begin
                    acc_re_r <= acc_re_r - ACC_W'(p_ii);
                    acc_im_r <= acc_im_r + ACC_W'(p_ir);
                end
                VSU_IDLE, VSU_STORE: ;
            endcase
        end
    end

    // Internal memory: software writes while idle, list stores while running
    logic st_en, st_two;
    logic [15:0] st_lo, st_hi;
    logic signed [ACC_W-1:0] st_src;
    assign st_src = madd_r ? madd_sum : acc_re_r;
    assign st_en = state_r == VSU_STORE || (state_r == VSU_VEC && madd_r);
    assign st_two = vtype_r == TY_CPX || vtype_r == TY_EXT;
    always_comb begin
        unique case (vtype_r)
            TY_INT: st_lo = st_src[15:0];
            TY_REAL: st_lo = st_src[FRAC_LSB +: 16];
            TY_CPX: st_lo = acc_re_r[FRAC_LSB +: 16];
            TY_EXT: st_lo = {acc_im_r[14:0], 1'b0};
        endcase
        st_hi = vtype_r == TY_CPX ? acc_im_r[FRAC_LSB +: 16] : acc_im_r[30:15];
    end
    always_ff @(posedge CLK_I) begin
        if (idle_wr && ram_hit && mapped) begin
            mem[ra({4'h0, PADDR_I[RAM_WIN_LSB-1:2]} & 16'h03FF)] <= PWDATA_I[15:0];
        end
        if (st_en) begin
            mem[ra(z_a)] <= st_lo;
            if (st_two) begin
                mem[ra(z_a + 16'h1)] <= st_hi;
            end
        end
    end

    // APB read data captured in the setup phase
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            prdata_r <= '0;
        end else if (PSEL_I && !PENABLE_I) begin
            if (ram_hit) begin
                prdata_r <= running ? '0 :
                    {16'h0, mem[ra({4'h0, PADDR_I[RAM_WIN_LSB-1:2]} & 16'h03FF)]};
            end else begin
                unique case (PADDR_I)
                    OFS_START: prdata_r <= {16'h0, pc_r};
                    OFS_STATUS: prdata_r <= {31'h0, running};
                    OFS_EXTBASE: prdata_r <= ext_base_r;
                    OFS_HALTFLG: prdata_r <= {31'h0, halt_irq_flags_r};
                    OFS_HALTMSK: prdata_r <= {31'h0, halt_irq_mask_r};
                    OFS_NMICAUSE: prdata_r <= {31'h0, undefined_op_flag_r};
                    OFS_PARAM: prdata_r <= param_r;
                    OFS_XPTR: prdata_r <= x_ptr_r;
                    OFS_YPTR: prdata_r <= y_ptr_r;
                    OFS_ZPTR: prdata_r <= z_ptr_r;
                    OFS_ACCRE: prdata_r <= acc_re_r[31:0];
                    OFS_ACCIM: prdata_r <= acc_im_r[31:0];
                    OFS_ACCHI: prdata_r <= {28'h0, acc_im_r[33:32], acc_re_r[33:32]};
                    default: prdata_r <= '0;
                endcase
            end
        end
    end

    assign PRDATA_O = prdata_r;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = apb_acc && !mapped;
    assign LIST_RUNNING_O = running;
    assign HALT_IRQ_O = halt_irq_flags_r && halt_irq_mask_r;
    assign NMI_REQ_O = undefined_op_flag_r;

    sequence s_undef_decode;
        dec_und && !abort_req;
    endsequence
    sequence s_ptr_load;
        (dec_lx || dec_ly || dec_lz) && !abort_req;
    endsequence

    a_undef_stops: assert property (s_undef_decode
        |=> !running && undefined_op_flag_r && NMI_REQ_O)
        else $error("undefined op did not stop list");
    a_undef_mask_kept: assert property (s_undef_decode
        |=> $stable(halt_irq_mask_r) && $stable(ext_base_r))
        else $error("undefined op altered mask");
    a_halt_flag_set: assert property ($fell(running) |-> halt_irq_flags_r)
        else $error("list ended without halt flag");
    a_lx_load_value: assert property (dec_lx && !abort_req |=> x_ptr_r == $past(dword))
        else $error("X pointer load wrong");
    a_ly_load_value: assert property (dec_ly && !abort_req |=> y_ptr_r == $past(dword))
        else $error("Y pointer load wrong");
    a_lz_load_value: assert property (dec_lz && !abort_req |=> z_ptr_r == $past(dword))
        else $error("Z pointer load wrong");
    a_ptr_acc_kept: assert property (s_ptr_load
        |=> $stable(acc_re_r) && $stable(acc_im_r))
        else $error("pointer load disturbed accumulator");
    a_vec_regs_const: assert property (state_r == VSU_VEC
        |=> $stable(x_ptr_r) && $stable(param_r)
        && $stable(y_ptr_r) && $stable(z_ptr_r) && $stable(ext_base_r))
        else $error("list changed a software register");
    a_clr_round_seed: assert property (dec_vec && opc == OP_VMAC
        && param_r[PAR_CLR_BIT] && arg_ty == TY_REAL && !abort_req
        |=> acc_re_r[RND_BIT] == param_r[PAR_RND_BIT] && acc_im_r == acc_re_r)
        else $error("clear did not seed rounding bit");
    a_noclr_acc_kept: assert property (dec_vec && opc == OP_VMAC
        && !param_r[PAR_CLR_BIT] && !abort_req |=> $stable(acc_re_r))
        else $error("accumulate without clear altered accumulator");
    a_both_halves: assert property (state_r == VSU_VEC && vtype_r != TY_CPX
        |=> acc_re_r == acc_im_r)
        else $error("non-complex value not in both halves");
    a_int_no_round: assert property (dec_vec && arg_ty == TY_INT && !abort_req
        && opc == OP_VMAC && param_r[PAR_CLR_BIT] |=> acc_re_r == '0)
        else $error("integer operation rounded");
endmodule : vsu_cmd_decoder
`default_nettype wire

// ==== vsu_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module vsu_host (
    input wire logic clk_i, // Clock
    input wire logic pready_i, // Ready
    output logic psel_o, // Select
    output logic penable_o, // Enable
    output logic pwrite_o, // Direction
    output logic [15:0] paddr_o, // Address
    output logic [31:0] pwdata_o // Write data
);
    logic [32:0] exp_q[$];
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 16'h0000;
        pwdata_o = 32'h00000000;
    end
    // Idle edge first, so no signal is set twice in one step
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h00000000);
    endtask : rd
endmodule : vsu_host
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
    import vsu_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, running, halt_irq, nmi;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [31:0] lfsr = 32'hE1BB786B;
    logic [15:0] w [0:7];
    logic [15:0] prog [0:5];
    logic [31:0] acc_e;
    int fails = 0;
    int n_tests = 0;
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    vsu_cmd_decoder vsu_cmd_decoder_i (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .LIST_RUNNING_O(running), .HALT_IRQ_O(halt_irq), .NMI_REQ_O(nmi));
    vsu_host vsu_host_i (.clk_i(clk), .pready_i(pready), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic ram_wr(input int idx, input logic [15:0] v);
        vsu_host_i.wr(16'h1000 + 16'(4 * idx), {16'h0000, v});
    endtask : ram_wr
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && vsu_host_i.exp_q.size() > 0) begin
            chk({pslverr, prdata}, vsu_host_i.exp_q.pop_front());
        end
    end
    task automatic final_report();
        // A read that never completed is a miss as well
        fails += vsu_host_i.exp_q.size();
        $display("mismatches %0d of %0d comparisons", fails, n_tests);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic run_list(input logic [15:0] pc);
        int i;
        vsu_host_i.wr(OFS_START, {16'h0000, pc});
        @(posedge clk);
        chk({32'h0, running}, 33'h1);
        for (i = 0; i < 40 && running !== 1'b0; i++) @(posedge clk);
        chk({32'h0, running}, 33'h0);
        @(posedge clk);
    endtask : run_list
    initial begin
        #200000;
        fails++;
        final_report();
    end
    initial begin
        rst_n = 1'b0;
        // Odd argument on the Y load must be forced even
        prog = '{{OP_LA, 11'h006}, {OP_LX, 11'h000}, {OP_LY, 11'h003}, {OP_LZ, 11'h004},
            {OP_SPECIAL, ARG_HALT}, {5'h1F, 11'h000}};
        // Pointer high words keep to stored fields; acc words stay positive
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_next(lfsr);
            w[k] = lfsr[15:0] & (k > 5 ? 16'h7FFF : (k[0] ? 16'h01FF : 16'hFFFF));
        end
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        vsu_host_i.rd(OFS_STATUS, 33'h0);
        vsu_host_i.rd(OFS_NMICAUSE, 33'h0);
        for (int k = 0; k < 14; k++) begin
            ram_wr(k > 7 ? k + 8 : k, k > 7 ? prog[k - 8] : w[k]);
        end
        vsu_host_i.wr(OFS_PARAM, 32'h00030001);
        vsu_host_i.wr(OFS_HALTMSK, 32'h00000001);
        run_list(16'h0010);
        vsu_host_i.rd(OFS_XPTR, {1'b0, w[1], w[0]});
        vsu_host_i.rd(OFS_YPTR, {1'b0, w[3], w[2]});
        vsu_host_i.rd(OFS_ZPTR, {1'b0, w[5], w[4]});
        vsu_host_i.rd(OFS_ACCRE, {2'b00, w[6], 1'b1, 14'h0});
        vsu_host_i.rd(OFS_ACCIM, {2'b00, w[7], 1'b1, 14'h0});
        vsu_host_i.rd(OFS_PARAM, {1'b0, 32'h00030001});
        vsu_host_i.rd(OFS_HALTFLG, 33'h1);
        chk({32'h0, halt_irq}, 33'h1);
        vsu_host_i.wr(OFS_HALTFLG, 32'h00000001);
        @(posedge clk);
        chk({32'h0, halt_irq}, 33'h0);
        run_list(16'h0015);
        chk({32'h0, nmi}, 33'h1);
        chk({32'h0, halt_irq}, 33'h1);
        vsu_host_i.rd(OFS_NMICAUSE, 33'h1);
        vsu_host_i.rd(OFS_HALTMSK, 33'h1);
        vsu_host_i.rd(OFS_XPTR, {1'b0, w[1], w[0]});
        vsu_host_i.wr(OFS_NMICAUSE, 32'h00000001);
        @(posedge clk);
        chk({32'h0, nmi}, 33'h0);
        vsu_host_i.rd(16'h0040, 33'h100000000);
        // X: addr 2B, wrap 4, so element 0 sits at 28 + (2B mod 10) = 33
        ram_wr(8, 16'h002B);
        ram_wr(9, 16'h0040);
        ram_wr(10, 16'h0034);
        ram_wr(11, 16'h0000);
        // Result word apart from both sources
        ram_wr(12, 16'h0036);
        ram_wr(13, 16'h0000);
        ram_wr(51, w[6]);
        ram_wr(52, w[7]);
        ram_wr(24, {OP_LX, 11'h008});
        ram_wr(25, {OP_LY, 11'h00A});
        ram_wr(26, {OP_LZ, 11'h00C});
        ram_wr(27, {OP_VMAC, 9'h000, TY_REAL});
        ram_wr(28, {OP_SPECIAL, ARG_HALT});
        acc_e = 32'(w[6]) * 32'(w[7]) + 32'h00004000;
        run_list(16'h0018);
        vsu_host_i.rd(OFS_ACCRE, {1'b0, acc_e});
        vsu_host_i.rd(OFS_ACCIM, {1'b0, acc_e});
        vsu_host_i.rd(16'h10D8, {17'h00000, acc_e[30:15]});
        vsu_host_i.wr(OFS_PARAM, 32'h00000001);
        acc_e = acc_e + 32'(w[6]) * 32'(w[7]);
        run_list(16'h0018);
        vsu_host_i.rd(OFS_ACCRE, {1'b0, acc_e});
        vsu_host_i.rd(16'h10D8, {17'h00000, acc_e[30:15]});
        @(posedge clk);
        final_report();
    end
endmodule : tb
`default_nettype wire
